// File: audio_tx_consts.svh
`ifndef AUDIO_TX_CONSTS_SVH
`define AUDIO_TX_CONSTS_SVH
// register byte offsets
`define OFF_LEVEL        12'h004
`define OFF_DMA_CTRL     12'h008
`define OFF_IRQ_CONTROL  12'h00C
`define OFF_IRQ_STATUS   12'h010
`define OFF_TX_MODE      12'h014
`define OFF_TRANSFER_GO  12'h018
`define OFF_SAMPLE_PORT  12'h020
`define OFF_VALIDITY     12'h060
`define OFF_USER_BITS    12'h090
`define OFF_CHAN_STATUS  12'h0C0
`define OFF_BURST_INFO   12'h100
`define OFF_BURST_REPEAT 12'h104
`define OFF_BINFO_SHADOW 12'h108
`define OFF_BREP_SHADOW  12'h10C
`define OFF_USER_SHADOW  12'h190
// table geometry
`define WORDS_PER_TABLE  12
`define TABLE_SPAN       12'h030
// irq_control fields
`define BIT_USERDATA_CLR 17
`define BIT_BLOCKEND_CLR 16
`define THR_MSB          9
`define THR_LSB          5
// shared enable/status positions
`define BIT_EMPTY        4
`define BIT_BLOCKEND     3
`define BIT_USERDATA     2
// dma control fields
`define DMA_EN_BIT       5
`define DMA_LVL_MSB      4
// sample buffer
`define BUF_DEPTH        32
`define BUF_AW           5
// framing
`define FRAMES_PER_BLOCK 8'd192
`define BITS_PER_FRAME   5'd31
`define BIT_DIV          4'd3
// burst-info fields
`define PD_MSB           31
`define PD_LSB           16
`define BITSTREAM_NUMBER_MSB        15
`define BITSTREAM_NUMBER_LSB        13
`define DINFO_MSB        12
`define DINFO_LSB        8
`define PAYLOAD_ERROR_FLAG_BIT      7
`define TYPE_MSB         6
`define TYPE_NULL        7'h00
`define TYPE_PAUSE       7'h03
`endif

// File: audio_tx_pkg.sv
package audio_tx_pkg;
  typedef enum logic {TX_IDLE, TX_RUN} tx_state_t;
  typedef struct packed {
    logic [4:0] threshold;
    logic       empty_en;
    logic       blockend_en;
    logic       userdata_en;
  } irq_ctrl_t;
  typedef struct packed {
    logic empty;
    logic blockend;
    logic userdata;
  } irq_stat_t;
  typedef struct packed {
    logic [15:0] payload_length_word;
    logic [2:0]  bitstream_number;
    logic [4:0]  type_dependent_info;
    logic        payload_error_flag;
    logic [6:0]  payload_type_code;
  } burst_info_t;
endpackage

// File: audio_tx_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "audio_tx_consts.svh"
// Operation
// R1 - write one bit 17 clears userdata irq
// R2 - write one bit 16 clears blockend irq
// R3 - bits 9:5 threshold, bit 4 enable
// R4 - bit 3: block or repetition end irq
// R5 - bit 2: irq on user shadow copy
// R6 - status bits 4,3,2 active high
// R7 - transfer bit 0 starts; upper bits zero
// R8 - validity: sub1 high half, sub0 low
// R9 - user/status words: sub1 high, sub0 low
// R10 - burst-info 31:16 payload length word
// R11 - bits 15:13 bitstream, 12:8 type info
// R12 - bit 7 payload error flag
// R13 - bits 6:0 type code, null, pause
// R14 - repeat period in bits 15:0
// R15 - read-only burst shadows at 0x108,0x10C
// R16 - repeat counted in frames sync-to-sync
// R17 - burst shadows load after blockend irq
// R18 - idle: user shadows track user words
// R19 - running: user shadows load on handover
// R20 - software preloads 384 user bits
// R21 - status/validity writes act at once
// R22 - dma request when level <= watermark
// R23 - sample write pushes, transmit pops
// R24 - empty sets at/below threshold; irq OR
// R25 - write one status bit clears it
module audio_tx_ctrl
  import audio_tx_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  logic        irq,
  output var  logic        dma_tx_req,
  output var  logic        tx_serial
);
  irq_ctrl_t   ctrl_q;
  irq_stat_t   stat_q;
  irq_stat_t   stat_d;
  tx_state_t   state_q;
  burst_info_t binfo_q;
  burst_info_t binfo_shd_q;
  logic [15:0] rep_q;
  logic [15:0] rep_shd_q;
  logic        nonlinear_q;
  logic [5:0]  dma_q;
  logic [31:0] val_mem [`WORDS_PER_TABLE];
  logic [31:0] usr_mem [`WORDS_PER_TABLE];
  logic [31:0] chs_mem [`WORDS_PER_TABLE];
  logic [31:0] usr_shd [`WORDS_PER_TABLE];
  logic [31:0] buf_mem [`BUF_DEPTH];
  logic [4:0]  wr_ptr_q;
  logic [4:0]  rd_ptr_q;
  logic [5:0]  level_q;
  logic [3:0]  div_q;
  logic [4:0]  bit_q;
  logic [31:0] shift_q;
  logic [7:0]  blk_cnt_q;
  logic [15:0] rep_cnt_q;
  logic        blk_evt_q;
  logic        first_q;
  logic [31:0] rdata_d;
  logic        hit_d;

  // apb access phase strobes
  wire         acc     = psel & penable & pready;
  wire         wr      = acc & pwrite;
  wire         rd_ph   = psel & penable & ~pready;
  wire [11:0]  val_rel = paddr - `OFF_VALIDITY;
  wire [11:0]  usr_rel = paddr - `OFF_USER_BITS;
  wire [11:0]  chs_rel = paddr - `OFF_CHAN_STATUS;
  wire [11:0]  ush_rel = paddr - `OFF_USER_SHADOW;
  wire         in_val  = paddr >= `OFF_VALIDITY &&
                         val_rel < `TABLE_SPAN && paddr[1:0] == 2'h0;
  wire         in_usr  = paddr >= `OFF_USER_BITS &&
                         usr_rel < `TABLE_SPAN && paddr[1:0] == 2'h0;
  wire         in_chs  = paddr >= `OFF_CHAN_STATUS &&
                         chs_rel < `TABLE_SPAN && paddr[1:0] == 2'h0;
  wire         in_ush  = paddr >= `OFF_USER_SHADOW &&
                         ush_rel < `TABLE_SPAN && paddr[1:0] == 2'h0;
  wire [3:0]   val_idx = val_rel[5:2];
  wire [3:0]   usr_idx = usr_rel[5:2];
  wire [3:0]   chs_idx = chs_rel[5:2];
  wire [3:0]   ush_idx = ush_rel[5:2];
  wire         wr_ctrl = wr && paddr == `OFF_IRQ_CONTROL;
  wire         wr_stat = wr && paddr == `OFF_IRQ_STATUS;
  wire         running = state_q == TX_RUN;

  // transmit timing
  wire         bit_tick    = running && div_q == `BIT_DIV;
  wire         frame_start = bit_tick && bit_q == `BITS_PER_FRAME;
  wire         buf_full    = level_q == 6'(`BUF_DEPTH);
  wire         push        = wr && paddr == `OFF_SAMPLE_PORT && !buf_full;
  wire         pop         = frame_start && level_q != 6'h00;
  wire         blk_wrap    = blk_cnt_q == `FRAMES_PER_BLOCK - 8'h01;
  wire         rep_wrap    = rep_shd_q != 16'h0000 &&
                             rep_cnt_q == rep_shd_q - 16'h0001;
  // first frame after start opens a block and ends none
  wire         handover    = frame_start && blk_wrap && !first_q;
  wire         blk_event   = frame_start && !first_q &&
                             (nonlinear_q ? rep_wrap : blk_wrap);
  // repeat count restarts at each burst sync and at the first frame
  wire         rep_restart = first_q || rep_wrap ||
                             (blk_wrap && rep_shd_q == 16'h0000);
  wire         below_thr   = level_q <= {1'b0, ctrl_q.threshold};

  // flag updates; a set in the clear cycle wins
  always_comb begin
    stat_d = stat_q;
    if (wr_stat && pwdata[`BIT_EMPTY]) begin
      stat_d.empty = 1'b0; // R25
    end
    if ((wr_ctrl && pwdata[`BIT_BLOCKEND_CLR]) ||
        (wr_stat && pwdata[`BIT_BLOCKEND])) begin
      stat_d.blockend = 1'b0; // R2 R25
    end
    if ((wr_ctrl && pwdata[`BIT_USERDATA_CLR]) ||
        (wr_stat && pwdata[`BIT_USERDATA])) begin
      stat_d.userdata = 1'b0; // R1 R25
    end
    if (running && below_thr) begin
      stat_d.empty = 1'b1; // R24
    end
    if (blk_event) begin
      stat_d.blockend = 1'b1; // R4
    end
    if (handover) begin
      stat_d.userdata = 1'b1; // R5
    end
  end

  // register read mux
  always_comb begin
    rdata_d = 32'h0000_0000;
    hit_d   = 1'b1;
    if (in_val) begin
      rdata_d = val_mem[val_idx]; // R8
    end else if (in_usr) begin
      rdata_d = usr_mem[usr_idx]; // R9
    end else if (in_chs) begin
      rdata_d = chs_mem[chs_idx]; // R9
    end else if (in_ush) begin
      rdata_d = usr_shd[ush_idx];
    end else begin
      case (paddr)
        `OFF_LEVEL:        rdata_d = {26'h0, level_q};
        `OFF_DMA_CTRL:     rdata_d = {26'h0, dma_q};
        `OFF_IRQ_CONTROL:  rdata_d = {22'h0, ctrl_q.threshold, // R3
                                      ctrl_q.empty_en, ctrl_q.blockend_en,
                                      ctrl_q.userdata_en, 2'h0};
        `OFF_IRQ_STATUS:   rdata_d = {27'h0, stat_q, 2'h0}; // R6
        `OFF_TX_MODE:      rdata_d = {31'h0, nonlinear_q};
        `OFF_TRANSFER_GO:  rdata_d = {31'h0, running}; // R7
        `OFF_SAMPLE_PORT:  rdata_d = 32'h0000_0000;
        `OFF_BURST_INFO:   rdata_d = binfo_q; // R10 R11 R12 R13
        `OFF_BURST_REPEAT: rdata_d = {16'h0, rep_q}; // R14
        `OFF_BINFO_SHADOW: rdata_d = binfo_shd_q; // R15
        `OFF_BREP_SHADOW:  rdata_d = {16'h0, rep_shd_q}; // R15
        default:           hit_d   = 1'b0;
      endcase
    end
  end

  // apb answer: one wait cycle, then data and ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= rd_ph;
      prdata  <= rd_ph && !pwrite ? rdata_d : 32'h0000_0000;
      pslverr <= rd_ph && !hit_d;
    end
  end

  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q      <= '0;
      stat_q      <= '0;
      nonlinear_q <= 1'b0;
      dma_q       <= 6'h00;
      binfo_q     <= '0;
      rep_q       <= 16'h0000;
      state_q     <= TX_IDLE;
    end else begin
      stat_q <= stat_d;
      if (wr_ctrl) begin
        ctrl_q <= {pwdata[`THR_MSB:`THR_LSB], pwdata[`BIT_EMPTY],
                   pwdata[`BIT_BLOCKEND], pwdata[`BIT_USERDATA]}; // R3
      end
      if (wr && paddr == `OFF_TX_MODE) begin
        nonlinear_q <= pwdata[0];
      end
      if (wr && paddr == `OFF_DMA_CTRL) begin
        dma_q <= pwdata[5:0];
      end
      if (wr && paddr == `OFF_BURST_INFO) begin
        binfo_q <= pwdata; // R10 R11 R12 R13
      end
      if (wr && paddr == `OFF_BURST_REPEAT) begin
        rep_q <= pwdata[15:0]; // R14
      end
      if (wr && paddr == `OFF_TRANSFER_GO) begin
        state_q <= pwdata[0] ? TX_RUN : TX_IDLE; // R7
      end
    end
  end

  // direct tables and user shadows, one per word
  genvar gi;
  generate
    for (gi = 0; gi < `WORDS_PER_TABLE; gi++) begin : g_word
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          val_mem[gi] <= 32'h0000_0000;
          usr_mem[gi] <= 32'h0000_0000;
          chs_mem[gi] <= 32'h0000_0000;
          usr_shd[gi] <= 32'h0000_0000;
        end else begin
          if (wr && in_val && val_idx == 4'(gi)) begin
            val_mem[gi] <= pwdata; // R21
          end
          if (wr && in_usr && usr_idx == 4'(gi)) begin
            usr_mem[gi] <= pwdata;
          end
          if (wr && in_chs && chs_idx == 4'(gi)) begin
            chs_mem[gi] <= pwdata; // R21
          end
          if (!running || handover) begin
            usr_shd[gi] <= usr_mem[gi]; // R18 R19
          end
        end
      end
    end
  endgenerate

  // burst shadows follow the blockend flag by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_evt_q   <= 1'b0;
      binfo_shd_q <= '0;
      rep_shd_q   <= 16'h0000;
    end else begin
      blk_evt_q <= blk_event;
      if (!running || blk_evt_q) begin
        binfo_shd_q <= binfo_q; // R17
        rep_shd_q   <= rep_q; // R17
      end
    end
  end

  // sample buffer
  always_ff @(posedge pclk) begin
    if (push) begin
      buf_mem[wr_ptr_q] <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= 5'h00;
      rd_ptr_q <= 5'h00;
      level_q  <= 6'h00;
    end else begin
      wr_ptr_q <= wr_ptr_q + 5'(push); // R23
      rd_ptr_q <= rd_ptr_q + 5'(pop); // R23
      level_q  <= level_q + 6'(push) - 6'(pop); // R23
    end
  end

  // bit and frame timing, serial shifter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q     <= 4'h0;
      bit_q     <= 5'h00;
      shift_q   <= 32'h0000_0000;
      blk_cnt_q <= 8'h00;
      rep_cnt_q <= 16'h0000;
      first_q   <= 1'b1;
    end else if (!running) begin
      div_q     <= 4'h0;
      bit_q     <= `BITS_PER_FRAME;
      shift_q   <= 32'h0000_0000;
      blk_cnt_q <= `FRAMES_PER_BLOCK - 8'h01;
      rep_cnt_q <= 16'h0000;
      first_q   <= 1'b1;
    end else begin
      div_q <= bit_tick ? 4'h0 : div_q + 4'h1;
      if (bit_tick) begin
        bit_q   <= bit_q + 5'h01;
        shift_q <= {shift_q[30:0], 1'b0};
      end
      if (frame_start) begin
        shift_q   <= pop ? buf_mem[rd_ptr_q] : 32'h0000_0000;
        blk_cnt_q <= blk_wrap ? 8'h00 : blk_cnt_q + 8'h01;
        rep_cnt_q <= rep_restart ? 16'h0000 : rep_cnt_q + 16'h0001; // R16
        first_q   <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq        <= 1'b0;
      dma_tx_req <= 1'b0;
      tx_serial  <= 1'b0;
    end else begin
      irq <= |(stat_d & {ctrl_q.empty_en, ctrl_q.blockend_en,
                         ctrl_q.userdata_en}); // R24
      dma_tx_req <= dma_q[`DMA_EN_BIT] &&
                    level_q <= {1'b0, dma_q[`DMA_LVL_MSB:0]}; // R22
      tx_serial  <= running & shift_q[31];
    end
  end

  sequence s_clear_ud;
    wr_ctrl && pwdata[`BIT_USERDATA_CLR] && !handover;
  endsequence
  sequence s_clear_be;
    wr_ctrl && pwdata[`BIT_BLOCKEND_CLR] && !blk_event;
  endsequence

  chk_userdata_clear: assert property (@(posedge pclk) // R1
    disable iff (!presetn) s_clear_ud |=> !stat_q.userdata)
    else $error("userdata flag not cleared");
  chk_blockend_clear: assert property (@(posedge pclk) // R2
    disable iff (!presetn) s_clear_be |=> !stat_q.blockend)
    else $error("blockend flag not cleared");
  chk_empty_thresh: assert property (@(posedge pclk) // R3
    disable iff (!presetn) running && below_thr |=> stat_q.empty)
    else $error("empty flag missed at threshold");
  chk_block_event: assert property (@(posedge pclk) // R4
    disable iff (!presetn) blk_event |=> stat_q.blockend)
    else $error("blockend event lost");
  chk_handover_flag: assert property (@(posedge pclk) // R5
    disable iff (!presetn)
    handover |=> stat_q.userdata && usr_shd[0] == $past(usr_mem[0]))
    else $error("handover not flagged");
  chk_status_read: assert property (@(posedge pclk) // R6
    disable iff (!presetn) rd_ph && !pwrite && paddr == `OFF_IRQ_STATUS
    |=> prdata == {27'h0, $past(stat_q), 2'h0})
    else $error("status read mismatch");
  chk_go_read: assert property (@(posedge pclk) // R7
    disable iff (!presetn) rd_ph && !pwrite && paddr == `OFF_TRANSFER_GO
    |=> prdata[31:1] == 31'h0000_0000)
    else $error("transfer register upper bits set");
  chk_shadow_hold: assert property (@(posedge pclk) // R17
    disable iff (!presetn) running && !blk_evt_q |=> $stable(rep_shd_q))
    else $error("repeat shadow moved early");
  chk_user_track: assert property (@(posedge pclk) // R18
    disable iff (!presetn)
    !running ##1 !running |-> usr_shd[1] == $past(usr_mem[1]))
    else $error("idle shadow not tracking");
  // a clear in the same cycle lowers the line, so it is left out
  chk_irq_or: assert property (@(posedge pclk) // R24
    disable iff (!presetn)
    stat_q.blockend && ctrl_q.blockend_en &&
    !(wr_ctrl && pwdata[`BIT_BLOCKEND_CLR]) &&
    !(wr_stat && pwdata[`BIT_BLOCKEND]) |=> irq)
    else $error("irq not raised");
  chk_level_push: assert property (@(posedge pclk) // R23
    disable iff (!presetn) push && !pop |=> level_q == $past(level_q) + 6'h01)
    else $error("level not incremented");
endmodule
`default_nettype wire

// File: audio_rx_model.sv
`timescale 1ns/100ps
`default_nettype none
// far-side receiver: oversamples the line, hunts for one word
module audio_rx_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        line,
  input  wire logic [31:0] want,
  output var  logic        found
);
  logic [127:0] hist;
  logic [31:0]  word;
  // one sample per bit cell of four clocks, oldest bit is the msb
  always_comb begin
    for (int k = 0; k < 32; k++) begin
      word[k] = hist[4*k];
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hist  <= '0;
      found <= 1'b0;
    end else begin
      hist <= {hist[126:0], line};
      if (word === want) begin
        found <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: audio_tx_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module audio_tx_ctrl_tb;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        pready, pslverr, irq, dma_tx_req, tx_serial, found, rerr;
  logic [31:0] want;
  int          mismatches, compares, cyc;
  time         t0;

  audio_tx_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .dma_tx_req(dma_tx_req), .tx_serial(tx_serial));
  audio_rx_model i_rx (.clk(pclk), .rst_n(presetn), .line(tx_serial),
    .want(want), .found(found));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task final_report;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      final_report();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rdat, exp);
  endtask

  // step at least one edge so a line just cleared is not seen again
  task wait_irq;
    @(posedge pclk);
    while (irq !== 1'b1) @(posedge pclk);
  endtask

  task t_reset;
    rdc(12'h010, 32'h0000_0000);
    rdc(12'h018, 32'h0000_0000);
    rdc(12'h108, 32'h0000_0000);
    rdc(12'h10C, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    $display("reset values done");
  endtask

  task t_map;
    apb(1'b0, 12'h7FC, 32'h0000_0000);
    check({31'h0, rerr}, 32'h0000_0001);
    wr(12'h00C, 32'hFFFF_FFFF);
    rdc(12'h00C, 32'h0000_03FC);
    wr(12'h00C, 32'h0000_0000);
    wr(12'h018, 32'hFFFF_FFFF);
    rdc(12'h018, 32'h0000_0001);
    wr(12'h018, 32'h0000_0000);
    wr(12'h010, 32'h0000_001C);
    rdc(12'h010, 32'h0000_0000);
    wr(12'h104, 32'hFFFF_FFFF);
    rdc(12'h104, 32'h0000_FFFF);
    wr(12'h10C, 32'h0000_0000);
    rdc(12'h10C, 32'h0000_FFFF);
    $display("register map done");
  endtask

  task t_tables;
    logic [11:0] a;
    logic [31:0] v;
    logic [6:0]  code [2];
    code[0] = 7'h00;
    code[1] = 7'h03;
    for (int i = 0; i < 12; i = i + 11) begin
      a = 12'(4 * i);
      v = 32'hFEDC_0001 + 32'(i);
      wr(12'h060 + a, v);
      rdc(12'h060 + a, v);
      wr(12'h090 + a, ~v);
      rdc(12'h090 + a, ~v);
      rdc(12'h190 + a, ~v);
      wr(12'h0C0 + a, {v[15:0], v[31:16]});
      rdc(12'h0C0 + a, {v[15:0], v[31:16]});
    end
    for (int j = 0; j < 2; j++) begin
      v = {16'h1234, 3'h5, 5'h15, 1'b1, code[j]};
      wr(12'h100, v);
      rdc(12'h100, v);
      rdc(12'h108, v);
    end
    $display("tables done");
  endtask

  task t_level;
    want = 32'hC3A5_96F0;
    for (int j = 0; j < 3; j++) begin
      wr(12'h020, want ^ 32'(j));
    end
    rdc(12'h004, 32'h0000_0003);
    wr(12'h008, 32'h0000_0023);
    repeat (2) @(posedge pclk);
    check({31'h0, dma_tx_req}, 32'h0000_0001);
    wr(12'h008, 32'h0000_0022);
    repeat (2) @(posedge pclk);
    check({31'h0, dma_tx_req}, 32'h0000_0000);
    wr(12'h00C, 32'h0000_0070);
    wr(12'h018, 32'h0000_0001);
    while (found !== 1'b1) @(posedge pclk);
    repeat (400) @(posedge pclk);
    rdc(12'h004, 32'h0000_0000);
    apb(1'b0, 12'h010, 32'h0000_0000);
    check({31'h0, rdat[4]}, 32'h0000_0001);
    check({31'h0, irq}, 32'h0000_0001);
    wr(12'h00C, 32'h0000_0060);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0000_0000);
    wr(12'h018, 32'h0000_0000);
    wr(12'h008, 32'h0000_0000);
    wr(12'h010, 32'h0000_001C);
    rdc(12'h010, 32'h0000_0000);
    $display("level and transmit done");
  endtask

  task t_block;
    wr(12'h090, 32'h1111_2222);
    wr(12'h100, 32'h0000_0003);
    wr(12'h00C, 32'h0000_000C);
    wr(12'h018, 32'h0000_0001);
    wr(12'h090, 32'h3333_4444);
    wr(12'h100, 32'h5678_0000);
    rdc(12'h190, 32'h1111_2222);
    rdc(12'h108, 32'h0000_0003);
    wait_irq();
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h010, 32'h0000_0000);
    check(rdat & 32'h0000_000C, 32'h0000_000C);
    rdc(12'h190, 32'h3333_4444);
    rdc(12'h108, 32'h5678_0000);
    wr(12'h00C, 32'h0002_000C);
    apb(1'b0, 12'h010, 32'h0000_0000);
    check(rdat & 32'h0000_000C, 32'h0000_0008);
    wr(12'h00C, 32'h0001_000C);
    apb(1'b0, 12'h010, 32'h0000_0000);
    check(rdat & 32'h0000_000C, 32'h0000_0000);
    wr(12'h018, 32'h0000_0000);
    $display("block handover done");
  endtask

  task t_repeat;
    wr(12'h014, 32'h0000_0001);
    wr(12'h104, 32'h0000_0002);
    wr(12'h00C, 32'h0000_0008);
    wr(12'h010, 32'h0000_001C);
    wr(12'h018, 32'h0000_0001);
    wait_irq();
    t0 = $time;
    wr(12'h00C, 32'h0001_0008);
    wait_irq();
    check(32'(($time - t0) / 25), 32'd256);
    wr(12'h018, 32'h0000_0000);
    wr(12'h014, 32'h0000_0000);
    $display("repetition period done");
  endtask

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    want    = 32'h0000_0000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_map();
    t_tables();
    t_level();
    t_block();
    t_repeat();
    final_report();
  end
endmodule
`default_nettype wire
